/* File: common/afc_pkg.sv */
// Constants and helpers shared by the ASCII frame checksum node
package afc_pkg;

  // ----------------------------------------------------------------
  // Clock and link timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned MAX_BPS = 115_200;
  // Shortest bit allowed, rounded up to whole cycles
  localparam int unsigned MIN_BIT_CYC_I = (CLK_HZ + MAX_BPS - 1) / MAX_BPS;
  localparam logic [15:0] MIN_BIT_CYC = MIN_BIT_CYC_I[15:0];
  localparam logic [3:0] CHAR_BITS = 4'hA;  // Start, eight data, stop
  localparam logic [3:0] DATA_BITS = 4'h8;

  // ----------------------------------------------------------------
  // Character codes and framing
  // ----------------------------------------------------------------
  localparam logic [7:0] CHR_CR = 8'h0D;
  localparam logic [7:0] PRINT_LO = 8'h20;
  localparam logic [7:0] PRINT_HI = 8'h7E;
  localparam logic [7:0] CHR_ZERO = 8'h30;
  localparam logic [7:0] CHR_NINE = 8'h39;
  localparam logic [7:0] CHR_A_UP = 8'h41;
  localparam logic [7:0] CHR_F_UP = 8'h46;
  localparam logic [7:0] HEX_ALPHA_OFS = 8'h37;
  localparam logic [3:0] NIB_TEN = 4'hA;
  localparam int unsigned CKSUM_CHARS = 2;
  localparam int unsigned ADDR_CHARS = 2;

  // Transmit phases of a response frame
  typedef enum logic [1:0] {TP_BODY, TP_CKH, TP_CKL, TP_CR} afc_tx_phase_t;

  // Receive bit engine states
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} afc_rx_state_t;

  // ----------------------------------------------------------------
  // Hex helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] nib_to_hex(input logic [3:0] n);
    nib_to_hex = (n < NIB_TEN) ? (CHR_ZERO + {4'h0, n}) : (HEX_ALPHA_OFS + {4'h0, n});
  endfunction : nib_to_hex

  // Returns {valid, nibble}; only upper-case digits are valid
  function automatic logic [4:0] hex_to_nib(input logic [7:0] c);
    logic [7:0] t;
    t = 8'h00;
    if (c >= CHR_ZERO && c <= CHR_NINE) begin
      t = c - CHR_ZERO;
      hex_to_nib = {1'b1, t[3:0]};
    end else if (c >= CHR_A_UP && c <= CHR_F_UP) begin
      t = c - HEX_ALPHA_OFS;
      hex_to_nib = {1'b1, t[3:0]};
    end else begin
      hex_to_nib = 5'h00;
    end
  endfunction : hex_to_nib

endpackage : afc_pkg

/* File: core/afc_fifo.sv */
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module afc_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = DEPTH[CW-1:0];
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic in_ready_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Occupancy after this edge; ready is registered from it so it leaves a flop
  assign cnt_d = (push && !pop) ? cnt_q + 1'b1 : (pop && !push) ? cnt_q - 1'b1 : cnt_q;
  assign in_ready = in_ready_q;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

  // Pointers wrap explicitly so any depth works, not just powers of two
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready_q <= 1'b1;
    end else begin
      if (push) wr_q <= (wr_q == LAST_IDX) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == LAST_IDX) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_d;
      in_ready_q <= (cnt_d != FULL_CNT);
    end
  end

  // Storage has no reset; valid masks stale entries
  always_ff @(posedge sys_clk) begin
    if (push) mem_q[wr_q] <= in_data;
  end

endmodule : afc_fifo
`default_nettype wire

/* File: core/afc_frame_node.sv */
// Serial frame receiver, checker and response framer of a bus node
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Only printable characters plus the closing carriage return form valid traffic.
// - With checksum on, two checksum characters precede the return; otherwise none.
// - Checksum is the byte sum of prefix, address, command and data, modulo 256.
// - Two-digit hex address selects one of 256 nodes; only own address answers.
// - Shared-pair driver is enabled only while a response is being sent.
// - Bit rate is limited to at most 115.2 kbit/s both ways.
// - Supervisory watchdog resets the node when its own system stops kicking.
// - User-set host timer drives outputs to a safe state when the host fails.
module afc_frame_node #(
  parameter int unsigned BUF_DEPTH = 16,
  parameter int unsigned FIFO_DEPTH = 4,
  parameter logic [31:0] WDOG_CYCLES = 32'h001E_8480,
  parameter logic [15:0] MIN_DIV = afc_pkg::MIN_BIT_CYC  // Rate floor in cycles per bit
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Configuration
  input wire logic [7:0] node_addr,
  input wire logic cksum_en,
  input wire logic [7:0] frame_prefix_char,
  input wire logic [15:0] bit_div,
  input wire logic [31:0] host_tmo,
  // Shared serial pair
  input wire logic line_rx,
  output logic line_tx,
  output logic line_tx_oe_n,
  // Supervision
  input wire logic sys_kick,
  output logic wdog_reset,
  output logic host_safe,
  // Accepted command
  output logic cmd_ok,
  output logic [7:0] cmd_len,
  output logic [BUF_DEPTH*8-1:0] cmd_body,
  // Response characters
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  input wire logic resp_last,
  output logic resp_ready
);

  // ----------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------
  // rate clamp
  wire [15:0] eff_div = (bit_div < MIN_DIV) ? MIN_DIV : bit_div;
  wire [15:0] half_div = {1'b0, eff_div[15:1]};
  logic srst_q;  // Watchdog pulse doubles as a soft reset of the link logic

  // ----------------------------------------------------------------
  // Receive bit engine, 8N1
  // ----------------------------------------------------------------
  afc_pkg::afc_rx_state_t rx_st_q;
  logic [15:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic rx_stb_q;
  wire rx_tick = (rx_cnt_q == '0);

  // Start is rechecked at mid-bit so a glitch does not open a character
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rx_st_q <= afc_pkg::RX_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      rx_stb_q <= 1'b0;
    end else begin
      rx_stb_q <= 1'b0;
      if (!rx_tick) rx_cnt_q <= rx_cnt_q - 1'b1;
      if (srst_q) begin
        rx_st_q <= afc_pkg::RX_IDLE;
      end else begin
        unique case (rx_st_q)
          afc_pkg::RX_IDLE: if (!line_rx) begin
            rx_st_q <= afc_pkg::RX_START;
            rx_cnt_q <= half_div;
          end
          afc_pkg::RX_START: if (rx_tick) begin
            rx_st_q <= line_rx ? afc_pkg::RX_IDLE : afc_pkg::RX_BITS;
            rx_cnt_q <= eff_div - 16'h1;  // Tick on the count of zero, so one less
            rx_bit_q <= '0;
          end
          afc_pkg::RX_BITS: if (rx_tick) begin
            rx_sh_q <= {line_rx, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 1'b1;
            rx_cnt_q <= eff_div - 16'h1;
            if (rx_bit_q == afc_pkg::DATA_BITS - 4'h1) rx_st_q <= afc_pkg::RX_STOP;
          end
          afc_pkg::RX_STOP: if (rx_tick) begin
            rx_st_q <= afc_pkg::RX_IDLE;
            rx_stb_q <= line_rx;  // Framing error drops the character
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame parser and checker
  // ----------------------------------------------------------------
  logic fr_act_q;
  logic [7:0] fr_len_q;
  logic [7:0] fr_sum_q;
  logic [7:0] p1_q;
  logic [7:0] p2_q;
  logic [7:0] buf_q [BUF_DEPTH];
  logic cmd_ok_q;
  logic [7:0] cmd_len_q;
  logic [BUF_DEPTH*8-1:0] cmd_body_q;

  localparam logic [7:0] BUF_MAX = BUF_DEPTH[7:0];
  localparam logic [7:0] CK_N = afc_pkg::CKSUM_CHARS[7:0];
  localparam logic [7:0] AD_N = afc_pkg::ADDR_CHARS[7:0];

  wire rx_print = (rx_sh_q >= afc_pkg::PRINT_LO) && (rx_sh_q <= afc_pkg::PRINT_HI);
  wire rx_is_pfx = (rx_sh_q == frame_prefix_char);
  wire rx_is_cr = (rx_sh_q == afc_pkg::CHR_CR);
  // sum of prefix to data, checksum chars taken back out
  wire [7:0] sum_body = cksum_en ? (fr_sum_q - p1_q - p2_q) : fr_sum_q;
  wire [7:0] body_len = cksum_en ? (fr_len_q - CK_N) : fr_len_q;
  wire [4:0] ck_hi = afc_pkg::hex_to_nib(p2_q);
  wire [4:0] ck_lo = afc_pkg::hex_to_nib(p1_q);
  wire [4:0] ad_hi = afc_pkg::hex_to_nib(buf_q[0]);
  wire [4:0] ad_lo = afc_pkg::hex_to_nib(buf_q[1]);
  wire ck_ok = !cksum_en || (ck_hi[4] && ck_lo[4] && {ck_hi[3:0], ck_lo[3:0]} == sum_body);
  wire ad_ok = ad_hi[4] && ad_lo[4] && ({ad_hi[3:0], ad_lo[3:0]} == node_addr);
  wire len_ok = (fr_len_q >= AD_N + (cksum_en ? CK_N : 8'h00));
  wire fr_end = rx_stb_q && fr_act_q && rx_is_cr;
  wire fr_good = fr_end && len_ok && ck_ok && ad_ok;
  wire fr_store = rx_stb_q && fr_act_q && !rx_is_pfx && !rx_is_cr && rx_print
                  && (fr_len_q != BUF_MAX);

  // prefix always opens a frame, bad characters abandon it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      fr_act_q <= 1'b0;
      fr_len_q <= '0;
      fr_sum_q <= '0;
      p1_q <= '0;
      p2_q <= '0;
    end else if (srst_q) begin
      fr_act_q <= 1'b0;
    end else if (rx_stb_q) begin
      if (rx_is_pfx) begin
        fr_act_q <= 1'b1;
        fr_len_q <= '0;
        fr_sum_q <= rx_sh_q;
      end else if (fr_store) begin
        fr_len_q <= fr_len_q + 1'b1;
        fr_sum_q <= fr_sum_q + rx_sh_q;
        p1_q <= rx_sh_q;
        p2_q <= p1_q;
      end else begin
        fr_act_q <= 1'b0;
      end
    end
  end

  // Character store, one slot per entry
  for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_buf
    always_ff @(posedge sys_clk) begin
      if (fr_store && fr_len_q == 8'(i)) buf_q[i] <= rx_sh_q;
    end
  end

  // only frames that pass every check are handed on
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cmd_ok_q <= 1'b0;
      cmd_len_q <= '0;
      cmd_body_q <= '0;
    end else begin
      cmd_ok_q <= fr_good;
      if (fr_good) begin
        cmd_len_q <= body_len;
        for (int k = 0; k < BUF_DEPTH; k++) cmd_body_q[k*8 +: 8] <= buf_q[k];
      end
    end
  end

  // ----------------------------------------------------------------
  // Supervisory watchdog and host timer
  // ----------------------------------------------------------------
  logic [31:0] wd_cnt_q;
  logic [31:0] host_cnt_q;
  logic safe_q;
  wire wd_fire = (wd_cnt_q == WDOG_CYCLES - 32'h1) && !sys_kick;
  wire host_fire = (host_tmo != '0) && (host_cnt_q == host_tmo - 32'h1) && !fr_good;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wd_cnt_q <= '0;
      srst_q <= 1'b0;
    end else begin
      srst_q <= wd_fire;
      wd_cnt_q <= (sys_kick || wd_fire) ? '0 : wd_cnt_q + 32'h1;
    end
  end

  // safe state on host silence; a same-cycle frame wins over expiry
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      host_cnt_q <= '0;
      safe_q <= 1'b0;
    end else begin
      host_cnt_q <= (fr_good || host_fire || host_tmo == '0) ? '0 : host_cnt_q + 32'h1;
      if (host_fire) safe_q <= 1'b1;
      else if (fr_good) safe_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Response path: FIFO, framer and bit engine
  // ----------------------------------------------------------------
  wire fo_valid;
  wire [8:0] fo_data;
  afc_pkg::afc_tx_phase_t tp_q;
  logic [9:0] tx_sh_q;
  logic [3:0] tx_left_q;
  logic [15:0] tx_cnt_q;
  logic [7:0] tx_sum_q;
  logic oe_n_q;
  logic tx_open_q;  // A response is under way and its return not yet loaded
  wire tx_idle = (tx_left_q == '0);
  wire tx_pop = tx_idle && (tp_q == afc_pkg::TP_BODY) && fo_valid && !srst_q;
  wire tx_load = tx_idle && !srst_q && ((tp_q != afc_pkg::TP_BODY) || fo_valid);
  wire [7:0] sum_next = tx_sum_q + fo_data[7:0];

  // checksum digits high first, then return
  logic [7:0] tx_chr;
  assign tx_chr = (tp_q == afc_pkg::TP_BODY) ? fo_data[7:0] :
                  (tp_q == afc_pkg::TP_CKH) ? afc_pkg::nib_to_hex(tx_sum_q[7:4]) :
                  (tp_q == afc_pkg::TP_CKL) ? afc_pkg::nib_to_hex(tx_sum_q[3:0]) :
                  afc_pkg::CHR_CR;

  afc_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_resp_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(resp_valid),
    .in_ready(resp_ready),
    .in_data({resp_last, resp_data}),
    .out_valid(fo_valid),
    .out_ready(tx_pop),
    .out_data(fo_data)
  );

  // phase order; checksum phases only when enabled
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tp_q <= afc_pkg::TP_BODY;
      tx_sum_q <= '0;
      tx_open_q <= 1'b0;
    end else if (srst_q) begin
      tp_q <= afc_pkg::TP_BODY;
      tx_sum_q <= '0;
      tx_open_q <= 1'b0;
    end else if (tx_load) begin
      tx_open_q <= (tp_q != afc_pkg::TP_CR);
      unique case (tp_q)
        afc_pkg::TP_BODY: begin
          tx_sum_q <= sum_next;
          if (fo_data[8]) tp_q <= cksum_en ? afc_pkg::TP_CKH : afc_pkg::TP_CR;
        end
        afc_pkg::TP_CKH: tp_q <= afc_pkg::TP_CKL;
        afc_pkg::TP_CKL: tp_q <= afc_pkg::TP_CR;
        afc_pkg::TP_CR: begin
          tp_q <= afc_pkg::TP_BODY;
          tx_sum_q <= '0;
        end
      endcase
    end
  end

  // Shifter idles high so the line bit is a plain flop
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tx_sh_q <= '1;
      tx_left_q <= '0;
      tx_cnt_q <= '0;
    end else if (srst_q) begin
      tx_sh_q <= '1;
      tx_left_q <= '0;
    end else if (tx_load) begin
      tx_sh_q <= {1'b1, tx_chr, 1'b0};
      tx_left_q <= afc_pkg::CHAR_BITS;
      tx_cnt_q <= eff_div - 16'h1;
    end else if (!tx_idle) begin
      if (tx_cnt_q == '0) begin
        tx_sh_q <= {1'b1, tx_sh_q[9:1]};
        tx_left_q <= tx_left_q - 1'b1;
        tx_cnt_q <= eff_div - 16'h1;
      end else begin
        tx_cnt_q <= tx_cnt_q - 1'b1;
      end
    end
  end

  // driver held from first start bit until the return's stop bit ends
  // Held across gaps between body characters, so a slow caller never drops the pair mid-frame
  wire tx_last_shift = (tx_left_q == 4'h1) && (tx_cnt_q == '0);
  wire drive_next = !srst_q && (tx_load || tx_open_q || (!tx_idle && !tx_last_shift));
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) oe_n_q <= 1'b1;
    else oe_n_q <= !drive_next;
  end

  // Outputs, each from a flop
  assign line_tx = tx_sh_q[0];
  assign line_tx_oe_n = oe_n_q;
  assign wdog_reset = srst_q;
  assign host_safe = safe_q;
  assign cmd_ok = cmd_ok_q;
  assign cmd_len = cmd_len_q;
  assign cmd_body = cmd_body_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_wd_fire; wd_fire; endsequence
  sequence s_one_pulse; srst_q ##1 !srst_q; endsequence

  a_print_only: assert property (
    tx_load |-> ((tx_chr >= afc_pkg::PRINT_LO && tx_chr <= afc_pkg::PRINT_HI)
                 || tx_chr == afc_pkg::CHR_CR)) else $error("non-printable character sent");
  a_ck_phase_gate: assert property (
    (tx_load && tp_q == afc_pkg::TP_BODY && fo_data[8] && !cksum_en) |=> tp_q == afc_pkg::TP_CR)
    else $error("checksum sent while disabled");
  a_rx_sum_match: assert property (
    fr_good && cksum_en |-> {ck_hi[3:0], ck_lo[3:0]} == fr_sum_q - p1_q - p2_q)
    else $error("frame accepted with wrong sum");
  a_addr_own: assert property (
    fr_good |=> cmd_ok && cmd_body[7:0] == buf_q[0] && ad_ok) else $error("foreign address taken");
  a_drive_release: assert property (
    (tx_idle && !tx_open_q && !fo_valid) [*2] |-> line_tx_oe_n)
    else $error("driver left on while idle");
  a_drive_held: assert property (
    tx_open_q |-> !line_tx_oe_n) else $error("driver dropped inside a response");
  a_bit_period: assert property (
    (tx_load && !srst_q) |=> tx_cnt_q >= MIN_DIV - 16'h1)
    else $error("bit faster than limit");
  a_wdog_pulse: assert property (
    s_wd_fire |=> s_one_pulse) else $error("watchdog reset not issued");
  a_safe_state: assert property (
    host_fire |=> host_safe [*2]) else $error("safe state not entered");
  a_hex_high_first: assert property (
    (tx_load && tp_q == afc_pkg::TP_CKH) |=> tx_sh_q[8:1] == afc_pkg::nib_to_hex(tx_sum_q[7:4]))
    else $error("checksum high digit wrong");
  a_bad_dropped: assert property (
    (fr_end && !ck_ok) |=> !cmd_ok) else $error("bad checksum frame passed");

endmodule : afc_frame_node
`default_nettype wire

/* File: verif/afc_host_model.sv */
// Behavioural host computer on the shared half-duplex serial pair
`timescale 1ns/10ps
`default_nettype none
module afc_host_model #(
  parameter int unsigned BIT_CYC = 1737
) (
  // Clock
  input wire logic sys_clk,
  // Shared pair
  input wire logic line_tx,
  input wire logic line_tx_oe_n,
  output logic line_rx
);
  logic host_bit = 1'b1;
  logic [7:0] rx_q[$];

  // ------------------------------------------------------------
  // Pair level
  // ------------------------------------------------------------
  // shared pair level
  // With no driver enabled the fail-safe bias holds the pair at idle high
  assign line_rx = line_tx_oe_n ? host_bit : line_tx;

  // ------------------------------------------------------------
  // Sending
  // ------------------------------------------------------------
  // one 8N1 character at the top rate
  task automatic send_char(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge sys_clk);
      host_bit = f[i];
      repeat (BIT_CYC - 1) @(negedge sys_clk);
    end
  endtask : send_char

  // frame closed by a carriage return
  // The caller supplies prefix, address, command, data and any checksum
  task automatic send_frame(input string s);
    for (int i = 0; i < s.len(); i++) begin
      send_char(8'(s[i]));
    end
    send_char(8'h0D);
  endtask : send_frame

  // ------------------------------------------------------------
  // Receiving
  // ------------------------------------------------------------
  // decode only what the node drives, sampling mid-bit
  initial begin : rx_loop
    logic [7:0] c;
    forever begin
      @(negedge line_rx);
      if (line_tx_oe_n) continue;
      repeat (BIT_CYC / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge sys_clk);
        c[i] = line_rx;
      end
      repeat (BIT_CYC) @(posedge sys_clk);
      rx_q.push_back(c);
    end
  end
endmodule : afc_host_model
`default_nettype wire

/* File: verif/afc_frame_node_test.sv */
// Self-checking bench of the frame node against a behavioural host
`timescale 1ns/10ps
`default_nettype none
module afc_frame_node_test;
  typedef struct {logic cks; string frm; logic ok;} afc_row_t;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic cksum_en = 1'b1;
  logic sys_kick = 1'b0;
  logic kick_on = 1'b1;
  logic resp_valid = 1'b0;
  logic [7:0] resp_data = 8'h00;
  logic resp_last = 1'b0;
  // Rate floor scaled down from the real cap so the run stays short
  localparam int unsigned BIT_CYC = 32;
  logic [7:0] node_addr = 8'h01;
  logic [7:0] frame_prefix_char = 8'h24;
  logic [15:0] bit_div = 16'h0010;
  logic line_rx, line_tx, line_tx_oe_n, wdog_reset, host_safe, cmd_ok, resp_ready;
  logic [7:0] cmd_len, len_cap;
  logic [127:0] cmd_body, body_cap;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int ok_cnt = 0;
  int ok_cyc = -1;
  int oe_run = 0;
  int oe_last = 0;
  int refused = 0;
  // Host frames: checksum option, frame without its return, acceptance
  afc_row_t rows[4] = '{'{1'b1, "$012B7", 1'b1}, '{1'b1, "$012B8", 1'b0},
                        '{1'b0, "$022", 1'b0}, '{1'b0, "$01A", 1'b1}};
  logic [7:0] body[6] = '{8'h21, 8'h30, 8'h31, 8'h34, 8'h30, 8'h30};

  // Bit divider set below the floor so an unclamped rate shows up
  afc_frame_node #(.WDOG_CYCLES(32'h0000_0040), .MIN_DIV(16'(BIT_CYC))) i_dut (
    .sys_clk(sys_clk), .reset(reset), .node_addr(node_addr), .cksum_en(cksum_en),
    .frame_prefix_char(frame_prefix_char), .bit_div(bit_div), .host_tmo(32'h0000_01F4),
    .line_rx(line_rx), .line_tx(line_tx), .line_tx_oe_n(line_tx_oe_n),
    .sys_kick(sys_kick), .wdog_reset(wdog_reset), .host_safe(host_safe),
    .cmd_ok(cmd_ok), .cmd_len(cmd_len), .cmd_body(cmd_body),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_last(resp_last),
    .resp_ready(resp_ready)
  );
  afc_host_model #(.BIT_CYC(BIT_CYC)) i_host (
    .sys_clk(sys_clk), .line_tx(line_tx), .line_tx_oe_n(line_tx_oe_n), .line_rx(line_rx)
  );

  // ------------------------------------------------------------
  // Clock, kicks and monitors
  // ------------------------------------------------------------
  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  // Kick every 8 cycles, capture accepted commands, time the driver enable
  always @(negedge sys_clk) begin
    cyc <= cyc + 1;
    sys_kick <= kick_on && (cyc % 8 == 0);
    if (cmd_ok === 1'b1) begin
      ok_cnt <= ok_cnt + 1;
      ok_cyc <= cyc;
      len_cap <= cmd_len;
      body_cap <= cmd_body;
    end
    if (line_tx_oe_n === 1'b0) oe_run <= oe_run + 1;
    else if (oe_run != 0) begin
      oe_last <= oe_run;
      oe_run <= 0;
    end
  end

  // Safe state follows 500 idle cycles after each accepted frame
  always @(negedge sys_clk) begin
    if (ok_cyc >= 0 && cyc == ok_cyc + 490) chk(host_safe === 1'b0, "host_safe early");
    if (ok_cyc >= 0 && cyc == ok_cyc + 510) chk(host_safe === 1'b1, "host_safe late");
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic good, input string msg);
    samples_checked++;
    if (good !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  function automatic logic [7:0] hexd(input logic [3:0] n);
    hexd = (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction : hexd

  // Hold the character until ready stands before a rising edge; count refused cycles
  task automatic push(input logic [7:0] d, input logic last);
    @(negedge sys_clk);
    resp_valid = 1'b1;
    resp_data = d;
    resp_last = last;
    while (resp_ready !== 1'b1) begin
      refused++;
      @(negedge sys_clk);
    end
  endtask : push

  task automatic end_sim;
    $display("checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int n;
    int len;
    int k;
    logic [7:0] sum;
    logic [7:0] exp_q[$];
    repeat (4) @(negedge sys_clk);
    chk(line_tx === 1'b1 && line_tx_oe_n === 1'b1, "pair not idle in reset");
    chk(cmd_ok === 1'b0 && wdog_reset === 1'b0 && resp_ready === 1'b1, "reset outputs");
    chk(afc_pkg::MIN_BIT_CYC === 16'h06C9, "rate cap");
    chk(host_safe === 1'b0, "host_safe in reset");
    reset = 1'b0;
    // Table of frames: good sum, bad sum, foreign address, no checksum
    foreach (rows[r]) begin
      n = ok_cnt;
      cksum_en = rows[r].cks;
      i_host.send_frame(rows[r].frm);
      repeat (20) @(negedge sys_clk);
      chk(ok_cnt == n + (rows[r].ok ? 1 : 0), "frame acceptance");
      len = rows[r].frm.len() - 1 - (rows[r].cks ? 2 : 0);
      if (rows[r].ok) chk(len_cap === 8'(len), "command length");
      for (int i = 0; i < len && rows[r].ok; i++) begin
        chk(body_cap[8*i +: 8] === 8'(rows[r].frm[i+1]), "command body");
      end
    end
    // New address and prefix: the old prefix no longer opens a frame
    node_addr = 8'h02;
    frame_prefix_char = 8'h23;
    cksum_en = 1'b0;
    n = ok_cnt;
    i_host.send_frame("$022");
    i_host.send_frame("#022");
    repeat (20) @(negedge sys_clk);
    chk(ok_cnt == n + 1, "address or prefix change");
    chk(len_cap === 8'h03 && body_cap[23:0] === 24'h32_32_30, "new address body");
    // Response of six characters overfills the four-word buffer
    cksum_en = 1'b1;
    sum = 8'h00;
    foreach (body[i]) begin
      push(body[i], i == 5);
      sum = sum + body[i];
      exp_q.push_back(body[i]);
    end
    @(negedge sys_clk);
    resp_valid = 1'b0;
    resp_last = 1'b0;
    exp_q.push_back(hexd(sum[7:4]));
    exp_q.push_back(hexd(sum[3:0]));
    exp_q.push_back(8'h0D);
    chk(refused > 0, "buffer never refused");
    for (k = 0; k < 20000 && oe_last == 0; k++) @(negedge sys_clk);
    // Nine characters at the capped rate, small load gaps allowed
    chk(oe_last >= 90 * BIT_CYC && oe_last <= 90 * BIT_CYC + 16, "driver enable span");
    chk(resp_ready === 1'b1, "buffer not drained");
    chk(i_host.rx_q.size() == 9, "response length");
    foreach (exp_q[i]) begin
      if (i < i_host.rx_q.size()) chk(i_host.rx_q[i] === exp_q[i], "response char");
    end
    // Stop kicking and time the supervisory reset
    do @(negedge sys_clk); while (sys_kick !== 1'b1);
    kick_on = 1'b0;
    for (k = 0; k < 200 && wdog_reset !== 1'b1; k++) @(negedge sys_clk);
    chk(k >= 63 && k <= 65, "watchdog timing");
    end_sim();
  end

  // Hang guard well beyond the expected run length
  initial begin
    repeat (30000) @(posedge sys_clk);
    num_errors++;
    $display("wrong value at %0t: run timed out", $time);
    end_sim();
  end
endmodule : afc_frame_node_test
`default_nettype wire
